//--- hw/tsa_pkg.sv
/*
 * shared constants and carriers for the two-wire slave with alarm pin
 * assumes one system clock; bus pins arrive asynchronously
 */
package tsa_pkg;
    // ----------------------------------------------------------------
    // byte framing
    // ----------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam int ADDR_HI_W = 4;
    localparam int ADDR_LO_W = 3;
    // arbitrary device-type value; not tied to any product
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
    localparam int TEMP_W = 12;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } tsa_bus_type;

    typedef struct packed {
        logic style;
        logic polarity;
    } tsa_alarm_cfg_type;

    localparam tsa_bus_type BUS_IDLE = '{scl: 1'b1, sda: 1'b1};
    localparam tsa_alarm_cfg_type CFG_RESET = '{style: 1'b0, polarity: 1'b0};

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WRITE = 7'h08,
        ST_WRITE_ACK = 7'h10,
        ST_READ = 7'h20,
        ST_READ_ACK = 7'h40
    } tsa_state_type;
endpackage

//--- hw/tsa_fifo.sv
/*
 * small fifo with a registered output word
 * assumes both sides on the same clock
 */
`timescale 1ns/10ps
module tsa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire empty = (count == '0);
    wire pop = !empty && (!out_valid || out_ready);

    // the output register holds one of the DEPTH words
    assign in_ready = ((count + (AW+1)'(out_valid)) != (AW+1)'(DEPTH));

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
                out_data <= mem[rptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // tsa_fifo

//--- hw/tsa_slave.sv
/*
 * two-wire serial slave with an open-drain alarm output
 * assumes scl, sda and address straps are asynchronous; the clock is much
 * faster than scl so every scl edge is seen; temperature and limits come
 * from logic on the same clock
 */
`timescale 1ns/10ps
// What this block does
// - command and write bits are taken from sda on each rising scl edge.
// - data that the block drives onto sda changes only after a falling scl edge.
// - sda is open drain: the block only pulls it low or lets it go.
// - the alarm goes active when the temperature passes the high or low limit.
// - the alarm works in comparator or interrupt style as chosen by a style bit.
// - after reset the alarm output is active low.
// - with the polarity bit set the alarm output is active high.
// - the three low address bits come from the address-select inputs.
// - the upper four address bits are fixed; a match is acked, a miss is nacked.
// - bytes go msb first, then a ninth clock carries the receiver's ack or nack.
// - a write to a read-only target is answered with a nack.
module tsa_slave #(
    parameter logic [3:0] DEV_TYPE = tsa_pkg::DEV_TYPE_DEFAULT,
    parameter int TW = tsa_pkg::TEMP_W,
    parameter int DEPTH = tsa_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] addr_select_inputs,
    // alarm pin
    output logic alert_out,
    output logic alert_oe,
    // alarm control
    input wire logic alarm_style_select,
    input wire logic alarm_polarity_bit,
    input wire logic alarm_clear,
    input wire logic signed [TW-1:0] temp,
    input wire logic signed [TW-1:0] limit_high,
    input wire logic signed [TW-1:0] limit_low,
    // write stream out
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    input wire logic wr_readonly,
    // read stream in
    input wire logic [7:0] rd_byte,
    output logic rd_take,
    output logic busy
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    tsa_pkg::tsa_bus_type bus_s1, bus_s2, bus_d;
    logic [2:0] addr_s1, addr_s2;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_s1 <= tsa_pkg::BUS_IDLE;
            bus_s2 <= tsa_pkg::BUS_IDLE;
            bus_d <= tsa_pkg::BUS_IDLE;
            addr_s1 <= '0;
            addr_s2 <= '0;
        end else begin
            bus_s1 <= '{scl: scl_in, sda: sda_in};
            bus_s2 <= bus_s1;
            bus_d <= bus_s2;
            addr_s1 <= addr_select_inputs;
            addr_s2 <= addr_s1;
        end
    end
    wire scl_rise = bus_s2.scl && !bus_d.scl;
    wire scl_fall = !bus_s2.scl && bus_d.scl;
    wire start_det = bus_s2.scl && bus_d.scl && bus_d.sda && !bus_s2.sda;
    wire stop_det = bus_s2.scl && bus_d.scl && !bus_d.sda && bus_s2.sda;

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    tsa_pkg::tsa_state_type state;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic ack_phase;
    logic drv;
    logic rw;
    logic master_ack;
    logic push;
    logic fifo_ready;
    wire [6:0] my_addr = {DEV_TYPE, addr_s2};
    wire addr_match = (shreg[7:1] == my_addr);
    wire byte_end = scl_rise && (bit_cnt == tsa_pkg::BIT_LAST);
    wire write_ok = !wr_readonly && fifo_ready;
    assign sda_out = 1'b0;
    assign sda_oe = drv;
    assign busy = (state != tsa_pkg::ST_IDLE);
    assign rd_take = scl_fall && ack_phase && ((state == tsa_pkg::ST_READ_ACK && master_ack)
                     || (state == tsa_pkg::ST_ADDR_ACK && rw));
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= tsa_pkg::ST_IDLE;
            shreg <= '0;
            bit_cnt <= tsa_pkg::BIT_FIRST;
            ack_phase <= 1'b0;
            drv <= 1'b0;
            rw <= 1'b0;
            master_ack <= 1'b0;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            if (start_det) begin
                state <= tsa_pkg::ST_ADDR;
                bit_cnt <= tsa_pkg::BIT_FIRST;
                ack_phase <= 1'b0;
                drv <= 1'b0;
            end else if (stop_det) begin
                state <= tsa_pkg::ST_IDLE;
                drv <= 1'b0;
            end else begin
                case (state)
                    tsa_pkg::ST_ADDR, tsa_pkg::ST_WRITE: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], bus_s2.sda};
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                        if (byte_end) begin
                            state <= (state == tsa_pkg::ST_ADDR) ? tsa_pkg::ST_ADDR_ACK
                                                                 : tsa_pkg::ST_WRITE_ACK;
                        end
                    end
                    tsa_pkg::ST_ADDR_ACK: begin
                        if (scl_fall && !ack_phase) begin
                            ack_phase <= addr_match;
                            drv <= addr_match;
                            rw <= shreg[0];
                            state <= addr_match ? tsa_pkg::ST_ADDR_ACK : tsa_pkg::ST_IDLE;
                        end else if (scl_fall) begin
                            ack_phase <= 1'b0;
                            bit_cnt <= tsa_pkg::BIT_FIRST;
                            if (rw) begin
                                state <= tsa_pkg::ST_READ;
                                shreg <= rd_byte;
                                drv <= !rd_byte[7];
                            end else begin
                                state <= tsa_pkg::ST_WRITE;
                                drv <= 1'b0;
                            end
                        end
                    end
                    tsa_pkg::ST_WRITE_ACK: begin
                        if (scl_fall && !ack_phase) begin
                            ack_phase <= 1'b1;
                            drv <= write_ok;
                            push <= write_ok;
                        end else if (scl_fall) begin
                            ack_phase <= 1'b0;
                            drv <= 1'b0;
                            state <= tsa_pkg::ST_WRITE;
                        end
                    end
                    tsa_pkg::ST_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                        if (byte_end) begin
                            state <= tsa_pkg::ST_READ_ACK;
                        end
                        if (scl_fall) begin
                            shreg <= {shreg[6:0], 1'b0};
                            drv <= !shreg[6];
                        end
                    end
                    tsa_pkg::ST_READ_ACK: begin
                        if (scl_fall && !ack_phase) begin
                            ack_phase <= 1'b1;
                            drv <= 1'b0;
                        end else if (scl_rise) begin
                            master_ack <= !bus_s2.sda;
                        end else if (scl_fall) begin
                            ack_phase <= 1'b0;
                            bit_cnt <= tsa_pkg::BIT_FIRST;
                            // a nack from the master ends the read; wait for stop
                            state <= master_ack ? tsa_pkg::ST_READ : tsa_pkg::ST_IDLE;
                            shreg <= rd_byte;
                            drv <= master_ack && !rd_byte[7];
                        end
                    end
                    default: begin
                        drv <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // write stream buffer
    // ----------------------------------------------------------------
    tsa_fifo #(.WIDTH(tsa_pkg::BYTE_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(shreg),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );
    // ----------------------------------------------------------------
    // alarm
    // ----------------------------------------------------------------
    tsa_pkg::tsa_alarm_cfg_type cfg;
    logic beyond_d;
    logic alarm_active;
    wire beyond = (temp > limit_high) || (temp < limit_low);
    wire beyond_new = beyond && !beyond_d;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= tsa_pkg::CFG_RESET;
            beyond_d <= 1'b0;
            alarm_active <= 1'b0;
        end else begin
            cfg <= '{style: alarm_style_select, polarity: alarm_polarity_bit};
            beyond_d <= beyond;
            if (!cfg.style) begin
                alarm_active <= beyond;
            end else if (beyond_new) begin
                alarm_active <= 1'b1;
            end else if (alarm_clear) begin
                alarm_active <= 1'b0;
            end
        end
    end

    // pull low when active and active low, or when idle and active high
    assign alert_out = 1'b0;
    assign alert_oe = alarm_active ^ cfg.polarity;
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_addr_slot;
        state == tsa_pkg::ST_ADDR_ACK && !ack_phase && scl_fall && !start_det && !stop_det;
    endsequence
    property p_sample_on_rise;
        (state == tsa_pkg::ST_WRITE) && $changed(shreg) |-> $past(scl_rise);
    endproperty
    a_sample_on_rise: assert property (p_sample_on_rise) else $error("shift without rise");
    property p_drive_on_fall;
        $changed(drv) |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda moved off fall");
    property p_open_drain;
        sda_oe |-> !sda_out && state != tsa_pkg::ST_IDLE;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high or idle");
    property p_addr_ack;
        s_addr_slot |=> drv == $past(addr_match);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    property p_addr_nack_idle;
        state == tsa_pkg::ST_ADDR_ACK && !ack_phase && scl_fall && !addr_match
            && !start_det && !stop_det |=> state == tsa_pkg::ST_IDLE && !drv;
    endproperty
    a_addr_nack_idle: assert property (p_addr_nack_idle) else $error("miss not idle");
    property p_addr_bits;
        my_addr[2:0] == addr_s2 && my_addr[6:3] == DEV_TYPE;
    endproperty
    a_addr_bits: assert property (p_addr_bits) else $error("address bits wrong");
    property p_ninth_clock;
        state == tsa_pkg::ST_WRITE && byte_end && !start_det && !stop_det
            |=> state == tsa_pkg::ST_WRITE_ACK;
    endproperty
    a_ninth_clock: assert property (p_ninth_clock) else $error("no ack slot");
    property p_readonly_nack;
        state == tsa_pkg::ST_WRITE_ACK && !ack_phase && scl_fall && wr_readonly
            && !start_det && !stop_det |=> !drv && !push;
    endproperty
    a_readonly_nack: assert property (p_readonly_nack) else $error("read-only acked");
    property p_reset_low;
        $rose(resetn) |-> !cfg.polarity && alert_oe == alarm_active;
    endproperty
    a_reset_low: assert property (@(posedge clk) p_reset_low) else $error("polarity");
    property p_polarity_high;
        cfg.polarity && alarm_active |-> !alert_oe;
    endproperty
    a_polarity_high: assert property (p_polarity_high) else $error("active high wrong");
    property p_comparator;
        !cfg.style && $stable(cfg.style) && beyond |=> alarm_active;
    endproperty
    a_comparator: assert property (p_comparator) else $error("alarm missed");
endmodule // tsa_slave

//--- sim/tsa_master.sv
/*
 * behavioural two-wire bus master: drives scl, pulls sda low or lets it go
 * assumes the bench resolves sda with a pull-up and calls these tasks
 */
`timescale 1ns/10ps
module tsa_master (
    // clock
    input wire logic clk,
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    logic in_bit;
    logic last_sda;
    int n_glitch;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        in_bit = 1'b0;
        n_glitch = 0;
    end

    // ----------------------------------------------------------------
    // watch sda while scl is high during a bit; first clock is skipped
    // because the slave may still be settling from the falling edge
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (in_bit && sda !== last_sda) n_glitch++;
        last_sda = sda;
    end

    // ----------------------------------------------------------------
    // bus phases; link period is eight system clocks
    // ----------------------------------------------------------------
    task automatic start_cond();
        repeat (2) @(posedge clk);
        sda_pull <= 1'b0;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_pull <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        repeat (2) @(posedge clk);
        sda_pull <= 1'b1;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_pull <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic clock_bit(input logic pull, output logic seen);
        repeat (2) @(posedge clk);
        sda_pull <= pull;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        @(posedge clk);
        in_bit <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        seen = sda;
        @(posedge clk);
        in_bit <= 1'b0;
        @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic byte_out(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(!b[i], s);
        clock_bit(1'b0, nack);
    endtask

    task automatic byte_in(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b0, b[i]);
        clock_bit(!nack, s);
    endtask
endmodule // tsa_master

//--- sim/tsa_slave_tb.sv
/*
 * self-checking bench for the two-wire slave and its alarm pin
 * assumes pull-ups on sda and the alarm line, and the package defaults
 */
`timescale 1ns/10ps
module tsa_slave_tb;
    logic clk, resetn, scl, m_pull, sda, sda_out, sda_oe, alert_out, alert_oe, alert_pin;
    logic [2:0] addr_select_inputs;
    logic alarm_style_select, alarm_polarity_bit, alarm_clear;
    logic signed [tsa_pkg::TEMP_W-1:0] temp, limit_high, limit_low;
    logic rx_valid, rx_ready, wr_readonly, rd_take, busy;
    logic [7:0] rx_data, rd_byte, v, exp0;
    logic [7:0] rx_q[$];
    logic [31:0] seed;
    int n_fail, cmp_count;
    localparam logic signed [11:0] TV [4] = '{12'sh1a0, 12'sh190, 12'sh010, 12'sh020};
    localparam logic [3:0] BEYOND = 4'h5;

    // ----------------------------------------------------------------
    // pins: both lines pulled up, every party may only pull low
    // ----------------------------------------------------------------
    assign sda = (m_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    assign alert_pin = (alert_oe && !alert_out) ? 1'b0 : 1'b1;

    tsa_master u_mst (.clk(clk), .scl(scl), .sda_pull(m_pull), .sda(sda));
    tsa_slave uut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_inputs(addr_select_inputs),
        .alert_out(alert_out), .alert_oe(alert_oe), .alarm_style_select(alarm_style_select),
        .alarm_polarity_bit(alarm_polarity_bit), .alarm_clear(alarm_clear), .temp(temp),
        .limit_high(limit_high), .limit_low(limit_low), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .wr_readonly(wr_readonly),
        .rd_byte(rd_byte), .rd_take(rd_take), .busy(busy));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic addr_phase(input logic [7:0] a, input logic exp_nack);
        logic nack;
        u_mst.start_cond();
        u_mst.byte_out(a, nack);
        check({7'h0, nack}, {7'h0, exp_nack});
    endtask

    task automatic put(input logic [7:0] d, input logic exp_nack);
        logic nack;
        if (!exp_nack) rx_q.push_back(d);
        u_mst.byte_out(d, nack);
        check({7'h0, nack}, {7'h0, exp_nack});
    endtask

    // ----------------------------------------------------------------
    // clock, rx monitor, read-byte supply, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            check(rx_data, rx_q.size() > 0 ? rx_q.pop_front() : 8'hxx);
        if (rd_take === 1'b1) rd_byte <= rd_byte + 8'h11;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        seed = 32'h0001_8237;
        addr_select_inputs = 3'h0;
        {alarm_style_select, alarm_polarity_bit, alarm_clear} = 3'h0;
        {rx_ready, wr_readonly} = 2'h2;
        temp = 12'sh100;
        limit_high = 12'sh190;
        limit_low = 12'sh020;
        rd_byte = 8'h00;
        n_fail = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check({7'h0, alert_pin}, 8'h01);
        // straps driven low, then random straps
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            if (k == 1) addr_select_inputs <= seed[18:16];
            repeat (4) @(posedge clk);
            addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs, 1'b0}, 1'b0);
            put(seed[7:0], 1'b0);
            put(seed[15:8], 1'b0);
            u_mst.stop_cond();
        end
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT ^ 4'h1, addr_select_inputs, 1'b0}, 1'b1);
        u_mst.stop_cond();
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs ^ 3'h4, 1'b0}, 1'b1);
        u_mst.stop_cond();
        // write to a read-only target, then repeated start into a read
        wr_readonly <= 1'b1;
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs, 1'b0}, 1'b0);
        put(8'h3c, 1'b1);
        wr_readonly <= 1'b0;
        seed = xs(seed);
        rd_byte <= seed[7:0];
        exp0 = seed[7:0];
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs, 1'b1}, 1'b0);
        u_mst.byte_in(v, 1'b0);
        check(v, exp0);
        u_mst.byte_in(v, 1'b1);
        check(v, exp0 + 8'h11);
        u_mst.stop_cond();
        // fill the buffer while the drain side stalls
        rx_ready <= 1'b0;
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs, 1'b0}, 1'b0);
        for (int i = 0; i < tsa_pkg::FIFO_DEPTH; i++) begin
            seed = xs(seed);
            put(seed[7:0], 1'b0);
        end
        put(8'ha5, 1'b1);
        u_mst.stop_cond();
        rx_ready <= 1'b1;
        repeat (30) @(posedge clk);
        check(8'(rx_q.size()), 8'h00);
        check({7'h0, busy}, 8'h00);
        check(8'(u_mst.n_glitch), 8'h00);
        // comparator style, both polarities, limits compared strictly
        for (int p = 0; p < 2; p++) begin
            alarm_polarity_bit <= p[0];
            for (int j = 0; j < 4; j++) begin
                temp <= TV[j];
                repeat (4) @(posedge clk);
                check({7'h0, alert_pin}, {7'h0, BEYOND[j] ~^ p[0]});
            end
        end
        // interrupt style latches until cleared
        alarm_polarity_bit <= 1'b0;
        alarm_style_select <= 1'b1;
        temp <= TV[0];
        repeat (4) @(posedge clk);
        temp <= TV[1];
        repeat (4) @(posedge clk);
        check({7'h0, alert_pin}, 8'h00);
        // host answers the alarm by reading the device
        addr_phase({tsa_pkg::DEV_TYPE_DEFAULT, addr_select_inputs, 1'b1}, 1'b0);
        u_mst.byte_in(v, 1'b1);
        check(v, exp0 + 8'h22);
        u_mst.stop_cond();
        alarm_clear <= 1'b1;
        @(posedge clk);
        alarm_clear <= 1'b0;
        repeat (4) @(posedge clk);
        check({7'h0, alert_pin}, 8'h01);
        end_of_test();
    end
endmodule // tsa_slave_tb
